//--- design/nv_access_pkg.sv
// Constants shared by the non-volatile data store access logic.
// Assumes an 8-bit CPU data-memory bus with a one-bit bank select.
package nv_access_pkg;

    // ========================================================
    // Register placement in the data-memory map
    localparam logic [7:0] LOC_ADDR   = 8'h1E;
    localparam logic [7:0] BYTE_ADDR  = 8'h1F;
    localparam logic [7:0] CTRL_ADDR  = 8'h40;
    localparam logic       CTRL_BANK  = 1'h1;

    // ========================================================
    // Field layout
    localparam int LOC_W            = 6;
    localparam int DEPTH            = 64;
    localparam int WRITE_PERMIT_BIT = 3;
    localparam int WRITE_START_BIT  = 2;
    localparam int READ_PERMIT_BIT  = 1;
    localparam int READ_START_BIT   = 0;

    // ========================================================
    // Reset values
    localparam logic [5:0] LOC_RESET  = 6'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

    // ========================================================
    // Timing
    localparam logic [2:0] READ_CYCLES = 3'h4;
    localparam logic [3:0] WRITE_TICKS = 4'h4;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_READ  = 2'b01,
        ST_WRITE = 2'b10
    } nv_state_e;

endpackage

//--- design/nv_array_if.sv
// Link between the access controller, the byte store and the write timer.
// Assumes all three parties run on the same system clock.
`timescale 1ns/1ps
interface nv_array_if;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic [7:0] rdata;
    logic       timer_start;
    logic       timer_done;

    modport ctrl  (output addr, output wdata, output wr_en, output timer_start,
                   input rdata, input timer_done);
    modport store (input addr, input wdata, input wr_en, output rdata);
    modport timer (input timer_start, output timer_done);
endinterface

//--- design/nv_byte_store.sv
// The 64 by 8 byte store, held in flip-flops with no reset.
// Assumes the controller presents one byte address at a time.
`timescale 1ns/1ps
module nv_byte_store
    import nv_access_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Array side
    nv_array_if.store arr
);

    logic [7:0] cells [DEPTH];

    // ========================================================
    // Storage
    // Contents survive reset, as a non-volatile store should.
    always_ff @(posedge ref_clk) begin
        if (arr.wr_en) begin
            cells[arr.addr] <= arr.wdata;
        end
    end

    assign arr.rdata = cells[arr.addr];

endmodule

//--- design/nv_write_timer.sv
// Write cycle timer paced by a free-running tick from its own oscillator.
// Assumes the tick pin is asynchronous to ref_clk and slower than it.
`timescale 1ns/1ps
module nv_write_timer
    import nv_access_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Oscillator tick
    input wire logic tick_pin,
    // Controller side
    nv_array_if.timer tmr
);

    logic       tick_meta;
    logic       tick_sync;
    logic       tick_prev;
    logic       busy;
    logic [3:0] ticks_left;

    // ========================================================
    // Tick synchroniser
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_meta <= 1'b0;
            tick_sync <= 1'b0;
            tick_prev <= 1'b0;
        end else begin
            tick_meta <= tick_pin;
            tick_sync <= tick_meta;
            tick_prev <= tick_sync;
        end
    end

    // ========================================================
    // Tick counter
    // The duration in system cycles varies with the oscillator phase.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy          <= 1'b0;
            ticks_left    <= 4'h0;
            tmr.timer_done <= 1'b0;
        end else begin
            tmr.timer_done <= 1'b0;
            if (tmr.timer_start) begin
                busy       <= 1'b1;
                ticks_left <= WRITE_TICKS;
            end else if (busy && tick_sync && !tick_prev) begin
                ticks_left <= ticks_left - 4'h1;
                if (ticks_left == 4'h1) begin
                    busy           <= 1'b0;
                    tmr.timer_done <= 1'b1;
                end
            end
        end
    end

endmodule

//--- design/nv_data_access.sv
// Byte access controller for the on-chip non-volatile data store.
// Assumes the CPU data-memory bus is synchronous to ref_clk.
// How it works
// - Store holds 64 bytes; each access moves exactly one byte.
// - Location and byte registers decode directly, whatever the bank select.
// - Location register keeps six bits, resets to zero, upper two read zero.
// - With write permit clear no write starts; one already running still reaches the store.
// - Write start is taken only when write permit was already set.
// - Hardware clears write start when the write cycle completes.
// - With read permit clear no read starts; one already running still completes.
// - Read start is taken only when read permit was already set.
// - Read end clears read start and loads the fetched byte.
// - Byte register holds until the next read or a bus write to it; a write cycle leaves it alone.
// - Control bits 7 to 4 read zero; four control bits reset zero.
// - Write end raises the done flag; servicing the interrupt clears it.
// - Write duration comes from an asynchronous timer, so it varies.
`timescale 1ns/1ps
module nv_data_access
    import nv_access_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // CPU data-memory bus
    input wire logic [7:0]  bus_addr,
    input wire logic        bus_bank,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [7:0]  bus_wdata,
    output logic     [7:0]  bus_rdata,
    // Write timer oscillator
    input wire logic        write_timer_tick,
    // Interrupt request
    input wire logic        write_done_ack,
    output logic            write_done_flag
);

    nv_array_if arr ();

    nv_state_e  state;
    logic [5:0] nv_location;
    logic [7:0] nv_byte;
    logic       write_permit;
    logic       write_start;
    logic       read_permit;
    logic       read_start;
    logic [2:0] read_count;
    logic [5:0] cyc_addr;
    logic [7:0] cyc_data;

    logic       sel_loc;
    logic       sel_byte;
    logic       sel_ctrl;
    logic       ctrl_wr;
    logic       take_write;
    logic       take_read;
    logic       read_end;
    logic       write_end;
    logic [7:0] ctrl_view;

    // ========================================================
    // Address decode
    assign sel_loc  = (bus_addr == LOC_ADDR);
    assign sel_byte = (bus_addr == BYTE_ADDR);
    assign sel_ctrl = (bus_addr == CTRL_ADDR) && (bus_bank == CTRL_BANK);
    assign ctrl_wr  = bus_wr && sel_ctrl;

    // A start is only honoured from idle, so a second start while a
    // cycle runs cannot corrupt the latched address or data.
    assign take_write = ctrl_wr && bus_wdata[WRITE_START_BIT]
                        && write_permit && (state == ST_IDLE);
    assign take_read  = ctrl_wr && bus_wdata[READ_START_BIT]
                        && read_permit && (state == ST_IDLE)
                        && !take_write;
    assign read_end   = (state == ST_READ) && (read_count == 3'h0);
    assign write_end  = (state == ST_WRITE) && arr.timer_done;

    assign ctrl_view = {4'h0, write_permit, write_start,
                        read_permit, read_start};

    // ========================================================
    // Cycle sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state      <= ST_IDLE;
            read_count <= 3'h0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (take_write) begin
                        state <= ST_WRITE;
                    end else if (take_read) begin
                        state      <= ST_READ;
                        read_count <= READ_CYCLES - 3'h1;
                    end
                end
                ST_READ: begin
                    if (read_end) begin
                        state <= ST_IDLE;
                    end else begin
                        read_count <= read_count - 3'h1;
                    end
                end
                ST_WRITE: begin
                    if (write_end) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ========================================================
    // Control register
    // Start bits are owned by hardware once set; software writes of zero
    // to them are ignored so that polling cannot be fooled.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            write_permit <= 1'b0;
            read_permit  <= 1'b0;
            write_start  <= 1'b0;
            read_start   <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                write_permit <= bus_wdata[WRITE_PERMIT_BIT];
                read_permit  <= bus_wdata[READ_PERMIT_BIT];
            end
            if (take_write) begin
                write_start <= 1'b1;
            end else if (write_end) begin
                write_start <= 1'b0;
            end
            if (take_read) begin
                read_start <= 1'b1;
            end else if (read_end) begin
                read_start <= 1'b0;
            end
        end
    end

    // ========================================================
    // Location and byte registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nv_location <= LOC_RESET;
        end else if (bus_wr && sel_loc) begin
            nv_location <= bus_wdata[5:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            nv_byte <= BYTE_RESET;
        end else if (read_end) begin
            nv_byte <= arr.rdata;
        end else if (bus_wr && sel_byte) begin
            nv_byte <= bus_wdata;
        end
    end

    // ========================================================
    // Cycle latch
    // Address and data are frozen at start, so software may touch the
    // registers while the slow write runs without changing its target.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cyc_addr <= LOC_RESET;
            cyc_data <= BYTE_RESET;
        end else if (take_write || take_read) begin
            cyc_addr <= nv_location;
            cyc_data <= nv_byte;
        end
    end

    assign arr.addr        = cyc_addr;
    assign arr.wdata       = cyc_data;
    assign arr.wr_en       = write_end;
    assign arr.timer_start = take_write;

    // ========================================================
    // Write done flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            write_done_flag <= 1'b0;
        end else if (write_end) begin
            write_done_flag <= 1'b1;
        end else if (write_done_ack) begin
            write_done_flag <= 1'b0;
        end
    end

    // ========================================================
    // Read data
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bus_rdata <= READ_ZERO;
        end else if (bus_rd) begin
            if (sel_loc) begin
                bus_rdata <= {2'h0, nv_location};
            end else if (sel_byte) begin
                bus_rdata <= nv_byte;
            end else if (sel_ctrl) begin
                bus_rdata <= ctrl_view;
            end else begin
                bus_rdata <= READ_ZERO;
            end
        end
    end

    // ========================================================
    // Sub-blocks
    nv_byte_store store_i (
        .ref_clk (ref_clk),
        .arr     (arr.store)
    );

    nv_write_timer timer_i (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .tick_pin (write_timer_tick),
        .tmr      (arr.timer)
    );

    // ========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    loc_upper_zero_a: assert property (
        bus_rd && sel_loc |=> bus_rdata[7:6] == 2'h0)
        else $error("location upper bits not zero");

    ctrl_upper_zero_a: assert property (
        bus_rd && sel_ctrl |=> bus_rdata[7:4] == 4'h0)
        else $error("control upper bits not zero");

    write_refused_a: assert property (
        ctrl_wr && !write_permit && state == ST_IDLE
        |=> state != ST_WRITE && !arr.wr_en)
        else $error("write started without permit");

    read_refused_a: assert property (
        ctrl_wr && !read_permit && state == ST_IDLE |=> state != ST_READ)
        else $error("read started without permit");

    write_begin_a: assert property (
        ctrl_wr && bus_wdata[WRITE_START_BIT] && write_permit
        && state == ST_IDLE |=> state == ST_WRITE && write_start)
        else $error("permitted write did not start");

    read_time_a: assert property (
        take_read |=> (state == ST_READ && read_start) [*4]
        ##1 (state == ST_IDLE && !read_start))
        else $error("read cycle length wrong");

    read_result_a: assert property (
        read_end |=> nv_byte == $past(arr.rdata) && !read_start)
        else $error("read result not loaded");

    write_finish_a: assert property (
        write_end |=> !write_start && write_done_flag && state == ST_IDLE)
        else $error("write end not reported");

    flag_set_wins_a: assert property (
        write_end && write_done_ack |=> write_done_flag)
        else $error("done flag lost to clear");

    byte_hold_a: assert property (
        !read_end && !(bus_wr && sel_byte) |=> $stable(nv_byte))
        else $error("byte register changed unasked");

    read_begin_a: assert property (
        ctrl_wr && bus_wdata[READ_START_BIT] && !bus_wdata[WRITE_START_BIT]
        && read_permit && state == ST_IDLE |=> state == ST_READ && read_start)
        else $error("permitted read did not start");

    byte_read_a: assert property (
        bus_rd && sel_byte |=> bus_rdata == $past(nv_byte))
        else $error("byte register read back wrong");

    start_bit_hold_a: assert property (
        write_start && !write_end |=> write_start)
        else $error("write start dropped early");

    cycle_latch_hold_a: assert property (
        state != ST_IDLE |=> $stable(cyc_addr) && $stable(cyc_data))
        else $error("latched address or data moved");

    read_seen_c: cover property (take_read ##[1:8] read_end);
    write_seen_c: cover property (take_write ##[1:1000] write_end);
    refused_seen_c: cover property (ctrl_wr && bus_wdata[WRITE_START_BIT]
                                    && !write_permit);
    flag_clash_c: cover property (write_end && write_done_ack);
    busy_start_c: cover property (ctrl_wr && bus_wdata[READ_START_BIT] && state == ST_WRITE);

endmodule

//--- dv/nv_cpu_model.sv
// Bus master model of the core that runs the application software.
// Assumes the block takes one strobe per rising edge of ref_clk.
`timescale 1ns/1ps
module nv_cpu_model
    import nv_access_pkg::*;
(
    // Clock
    input  wire logic       ref_clk,
    // Data-memory bus
    output logic      [7:0] bus_addr,
    output logic            bus_bank,
    output logic            bus_wr,
    output logic            bus_rd,
    output logic      [7:0] bus_wdata,
    input  wire logic [7:0] bus_rdata
);
    initial begin
        bus_addr  = 8'h00;
        bus_bank  = 1'b0;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_wdata = 8'h00;
    end

    // ========================================================
    // Bus cycles
    // Released lines show inverted data and bank zero, so a stale value never passes.
    task automatic wr(input logic [7:0] addr, input logic bank, input logic [7:0] data);
        @(negedge ref_clk);
        bus_addr  = addr;
        bus_bank  = bank;
        bus_wdata = data;
        bus_wr    = 1'b1;
        @(negedge ref_clk);
        bus_wr    = 1'b0;
        bus_bank  = 1'b0;
        bus_wdata = ~data;
    endtask

    task automatic rd(input logic [7:0] addr, input logic bank, output logic [7:0] data);
        @(negedge ref_clk);
        bus_addr = addr;
        bus_bank = bank;
        bus_rd   = 1'b1;
        @(negedge ref_clk);
        bus_rd   = 1'b0;
        bus_bank = 1'b0;
        data     = bus_rdata;
    endtask

    // The control register is only reached through bank one at 40H.
    task automatic ctrl_wr(input logic [7:0] data);
        wr(CTRL_ADDR, CTRL_BANK, data);
    endtask

    task automatic ctrl_rd(output logic [7:0] data);
        rd(CTRL_ADDR, CTRL_BANK, data);
    endtask
endmodule

//--- dv/data_eeprom_access_control_tb.sv
// Self-checking bench for the non-volatile byte access controller.
// Assumes the bus model drives all bus strobes at falling edges.
`timescale 1ns/1ps
module data_eeprom_access_control_tb
    import nv_access_pkg::*;
();
    logic       ref_clk;
    logic       rst;
    logic [7:0] bus_addr;
    logic       bus_bank;
    logic       bus_wr;
    logic       bus_rd;
    logic [7:0] bus_wdata;
    logic [7:0] bus_rdata;
    logic       write_timer_tick;
    logic       write_done_ack;
    logic       write_done_flag;
    int         num_errors;
    int         checks;

    nv_data_access u_nv_data_access (
        .ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr), .bus_bank(bus_bank),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .write_timer_tick(write_timer_tick), .write_done_ack(write_done_ack),
        .write_done_flag(write_done_flag));

    nv_cpu_model u_nv_cpu_model (
        .ref_clk(ref_clk), .bus_addr(bus_addr), .bus_bank(bus_bank), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

    // ========================================================
    // Clocks
    // The timer oscillator is unrelated in phase and slower than ref_clk.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        write_timer_tick = 1'b0;
        forever #85 write_timer_tick = ~write_timer_tick;
    end

    // ========================================================
    // Compare and close
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp1(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset();
        logic [7:0] v;
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h00, "control after reset");
        u_nv_cpu_model.rd(LOC_ADDR, 1'b0, v);
        cmp8(v, 8'h00, "location after reset");
        u_nv_cpu_model.rd(BYTE_ADDR, 1'b0, v);
        cmp8(v, 8'h00, "byte after reset");
        u_nv_cpu_model.rd(CTRL_ADDR, 1'b0, v);
        cmp8(v, 8'h00, "control in bank zero");
        cmp1(write_done_flag, 1'b0, "done flag after reset");
        u_nv_cpu_model.wr(LOC_ADDR, 1'b0, 8'hFF);
        u_nv_cpu_model.rd(LOC_ADDR, 1'b0, v);
        cmp8(v, 8'h3F, "location upper bits");
        u_nv_cpu_model.wr(LOC_ADDR, 1'b1, 8'h07);
        u_nv_cpu_model.rd(LOC_ADDR, 1'b0, v);
        cmp8(v, 8'h07, "location from bank one");
        $display("test reset done");
    endtask

    task automatic t_write_refused();
        logic [7:0] v;
        u_nv_cpu_model.ctrl_wr(8'hF4);
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h00, "start without permit");
        repeat (60) @(negedge ref_clk);
        cmp1(write_done_flag, 1'b0, "no write happened");
        $display("test write refused done");
    endtask

    task automatic t_write(input logic [7:0] loc, input logic [7:0] data);
        logic [7:0] v;
        int         n;
        u_nv_cpu_model.wr(LOC_ADDR, 1'b0, loc);
        u_nv_cpu_model.wr(BYTE_ADDR, 1'b1, data);
        u_nv_cpu_model.ctrl_wr(8'h08);
        u_nv_cpu_model.ctrl_wr(8'h0C);
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h0C, "write still running");
        n = 0;
        while (v[WRITE_START_BIT] !== 1'b0 && n < 200) begin
            u_nv_cpu_model.ctrl_rd(v);
            n++;
        end
        cmp8(v, 8'h08, "write start cleared");
        cmp1(write_done_flag, 1'b1, "done flag raised");
        @(negedge ref_clk);
        write_done_ack = 1'b1;
        @(negedge ref_clk);
        write_done_ack = 1'b0;
        cmp1(write_done_flag, 1'b0, "done flag serviced");
        $display("test write done");
    endtask

    task automatic t_read_refused();
        logic [7:0] v;
        u_nv_cpu_model.ctrl_wr(8'h00);
        u_nv_cpu_model.ctrl_wr(8'h01);
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h00, "read start without permit");
        repeat (8) @(negedge ref_clk);
        u_nv_cpu_model.rd(BYTE_ADDR, 1'b0, v);
        cmp8(v, 8'h5A, "byte untouched");
        $display("test read refused done");
    endtask

    task automatic t_read(input logic [7:0] loc, input logic [7:0] exp);
        logic [7:0] v;
        u_nv_cpu_model.ctrl_wr(8'h02);
        u_nv_cpu_model.wr(LOC_ADDR, 1'b0, loc);
        u_nv_cpu_model.ctrl_wr(8'h03);
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h03, "read running");
        @(negedge ref_clk);
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h02, "read start cleared");
        u_nv_cpu_model.rd(BYTE_ADDR, 1'b1, v);
        cmp8(v, exp, "fetched byte");
        $display("test read done");
    endtask

    task automatic t_hold();
        logic [7:0] v;
        u_nv_cpu_model.wr(LOC_ADDR, 1'b0, 8'h10);
        u_nv_cpu_model.ctrl_wr(8'h00);
        u_nv_cpu_model.rd(BYTE_ADDR, 1'b0, v);
        cmp8(v, 8'h5A, "byte held");
        u_nv_cpu_model.wr(BYTE_ADDR, 1'b0, 8'hC3);
        u_nv_cpu_model.rd(BYTE_ADDR, 1'b0, v);
        cmp8(v, 8'hC3, "byte written by software");
        $display("test hold done");
    endtask

    // The clear is held high across the write end, so the flag must still pulse.
    task automatic t_write_ack(input logic [7:0] loc, input logic [7:0] data);
        logic [7:0] v;
        int         n;
        write_done_ack = 1'b1;
        u_nv_cpu_model.wr(LOC_ADDR, 1'b1, loc);
        u_nv_cpu_model.wr(BYTE_ADDR, 1'b0, data);
        u_nv_cpu_model.ctrl_wr(8'h08);
        u_nv_cpu_model.ctrl_wr(8'h0C);
        u_nv_cpu_model.ctrl_wr(8'h0A);
        u_nv_cpu_model.ctrl_wr(8'h0B);
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h0E, "read start refused while busy");
        n = 0;
        while (write_done_flag !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        cmp1(write_done_flag, 1'b1, "flag set wins over clear");
        @(negedge ref_clk);
        cmp1(write_done_flag, 1'b0, "held clear takes flag down");
        write_done_ack = 1'b0;
        u_nv_cpu_model.ctrl_rd(v);
        cmp8(v, 8'h0A, "write start cleared under clear");
        $display("test write against clear done");
    endtask

    // ========================================================
    // Main sequence and watchdog
    initial begin
        num_errors     = 0;
        checks         = 0;
        write_done_ack = 1'b0;
        rst            = 1'b1;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_write_refused();
        t_write(8'h05, 8'hA5);
        t_write(8'h3F, 8'h5A);
        t_read_refused();
        t_read(8'h05, 8'hA5);
        t_read(8'h3F, 8'h5A);
        t_hold();
        t_write_ack(8'h20, 8'h96);
        t_read(8'h20, 8'h96);
        // A second reset clears the registers but must leave the store alone.
        rst = 1'b1;
        repeat (4) @(negedge ref_clk);
        rst = 1'b0;
        t_reset();
        t_read(8'h05, 8'hA5);
        close_out();
    end

    // The run needs well under 20 us; ten times that means a hang.
    initial begin
        #200000;
        num_errors++;
        $display("unexpected at %0t: watchdog ran out", $time);
        close_out();
    end
endmodule
